/* File: hdl/rpm_addr_decode.sv */
`timescale 1ns/10ps
`default_nettype none

module rpm_addr_decode
	import rpm_pkg::*;
(
	input wire logic [31:0] addr,
	output logic [SEL_N-1:0] sel,
	output logic unmapped
);

	function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	function automatic logic in_win(input logic [31:0] a, input logic [31:0] base);
		in_win = (a & APB_WIN_MASK) == base;
	endfunction : in_win

	always_comb begin
		sel = '0;
		sel[SEL_FLASH] = in_rng(addr, FLASH_BASE, FLASH_LAST);
		sel[SEL_SRAM] = in_rng(addr, SRAM_BASE, SRAM_LAST);
		sel[SEL_SYS] = in_rng(addr, SYS_BASE, SYS_LAST);
		sel[SEL_CLKC] = in_rng(addr, CLKC_BASE, CLKC_LAST);
		sel[SEL_INTM] = in_rng(addr, INTM_BASE, INTM_LAST);
		sel[SEL_GPIO] = in_rng(addr, GPIO_BASE, GPIO_LAST);
		sel[SEL_FLC] = in_rng(addr, FLC_BASE, FLC_LAST);
		sel[SEL_WDT] = in_rng(addr, WDT_BASE, WDT_LAST);
		sel[SEL_WINWD] = in_rng(addr, WINWD_BASE, WINWD_LAST);
		sel[SEL_TMR] = in_win(addr, TMR_BASE);
		sel[SEL_TW0] = in_win(addr, TW0_BASE);
		sel[SEL_SPI] = in_win(addr, SPI_BASE);
		sel[SEL_PWM] = in_win(addr, PWM_BASE);
		sel[SEL_SER0] = in_win(addr, SER0_BASE);
		sel[SEL_ACMP] = in_win(addr, ACMP_BASE);
		sel[SEL_ADC] = in_win(addr, ADC_BASE);
		sel[SEL_TW1] = in_win(addr, TW1_BASE);
		sel[SEL_SER1] = in_win(addr, SER1_BASE);
		sel[SEL_SYST] = in_rng(addr, SYST_BASE, SYST_LAST);
		sel[SEL_NVIC] = in_rng(addr, NVIC_BASE, NVIC_LAST);
		sel[SEL_SCB] = in_rng(addr, SCB_BASE, SCB_LAST);
		unmapped = ~|sel;
	end

endmodule : rpm_addr_decode

`default_nettype wire

/* File: hdl/rpm_filter.sv */
`timescale 1ns/10ps
`default_nettype none

// Stable-level filter: output follows the input only after it has held for CYC cycles
module rpm_filter #(
	parameter int CYC = 20,
	parameter logic INIT = 1'b0
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic raw,
	output logic level
);

	logic [15:0] cnt_q;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 16'h0000;
			level <= INIT;
		end else if (!enable) begin
			cnt_q <= 16'h0000;
			level <= INIT;
		end else if (raw == level) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q >= 16'(CYC - 1)) begin
			cnt_q <= 16'h0000;
			level <= raw;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

endmodule : rpm_filter

`default_nettype wire

/* File: hdl/rpm_manager.sv */
// Behaviour
// - Each reset source sets a status flag readable by software; both watchdogs share one flag.
// - POR, pin, watchdogs, low voltage, brown-out and lockup cause system reset.
// - Writing one to whole_chip_reset_bit resets the whole chip.
// - Writing one to core_only_reset_bit resets only the core.
// - Whole-chip reset reloads boot_select_bit from configuration.
// - system_reset_request_bit gives MCU reset keeping boot_select_bit software value.
// - Brown-out monitored only while brownout_enable is set.
// - Brown-out threshold chosen by two-bit level field.
// - Brown-out reset held until supply high longer than de-glitch time.
// - Power-up brown-out defaults come from user_config_word_zero bits 23, 22:21, 20.
// - External reset pin counts only after staying low 768 RC cycles.
// - Wait-for-interrupt without power-down enters Idle; any interrupt returns Normal.
// - Sleep-deep plus power-down plus wait-for-interrupt enters Power-down.
// - Power-down left only on chip or core reset or on watchdog, two-wire, timer, serial, brown-out, pin wake.
// - Two-wire falling edge on data or clock line wakes from Power-down.
// - Flash and SRAM decoded at their fixed ranges.
// - High-speed bus decode for system, clock, interrupt mux, pins, flash control.
// - Peripheral bus decode with 16 KB windows for timers and two-wire ports.
// - Core system control block and interrupt controller decoded.
`timescale 1ns/10ps
`default_nettype none

module rpm_manager
	import rpm_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic por_event,
	input wire logic external_reset_pin_n,
	input wire logic wdt_timeout,
	input wire logic window_wdt_timeout,
	input wire logic low_voltage_reset,
	input wire logic core_lockup,
	input wire logic avdd_below_low,
	input wire logic [3:0] avdd_below_lvl,
	input wire logic [31:0] user_config_word_zero,
	input wire logic ip_reset_wr,
	input wire logic [31:0] ip_reset_ctl_0,
	input wire logic aircr_wr,
	input wire logic [31:0] app_interrupt_reset_ctl,
	input wire logic brownout_ctl_wr,
	input wire logic [31:0] brownout_ctl,
	input wire logic boot_sel_wr,
	input wire logic boot_sel_wdata,
	input wire logic status_clr_wr,
	input wire logic [RS_N-1:0] status_clr_mask,
	input wire logic wfi,
	input wire logic sleep_deep,
	input wire logic pd_enable,
	input wire logic any_irq,
	input wire logic wake_wdt,
	input wire logic wake_timer,
	input wire logic wake_serial,
	input wire logic wake_brownout,
	input wire logic wake_gpio,
	input wire logic tw_sda,
	input wire logic tw_scl,
	input wire logic [31:0] bus_addr,
	output logic [RS_N-1:0] reset_source_status,
	output logic chip_rst,
	output logic core_rst,
	output logic boot_select_bit,
	output logic brownout_enable,
	output logic [1:0] brownout_level_select,
	output logic brownout_reset_enable,
	output logic brownout_detected,
	output logic brownout_int_flag,
	output logic [1:0] power_mode,
	output logic core_clk_en,
	output logic hclk_en,
	output logic [SEL_N-1:0] bus_sel,
	output logic bus_unmapped
);

	// ------------------------------------------------------------
	// Brown-out detector
	// ------------------------------------------------------------
	logic brn_raw;
	logic brn_low;
	logic pin_low;
	logic cfg_load_q;

	assign brn_raw = avdd_below_lvl[brownout_level_select];

	rpm_filter #(.CYC(BRN_GLITCH_CYC), .INIT(1'b0)) u_brn_flt (
		.clock(clock),
		.sys_rst(sys_rst),
		.enable(brownout_enable),
		.raw(brn_raw),
		.level(brn_low)
	);

	rpm_filter #(.CYC(EXT_RST_CYC), .INIT(1'b0)) u_pin_flt (
		.clock(clock),
		.sys_rst(sys_rst),
		.enable(1'b1),
		.raw(~external_reset_pin_n),
		.level(pin_low)
	);

	assign brownout_detected = brn_low;

	// Defaults load on the first edge after release, since an async reset may only load constants
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_load_q <= 1'b1;
		end else begin
			cfg_load_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			brownout_enable <= 1'b0;
			brownout_level_select <= 2'h0;
			brownout_reset_enable <= 1'b0;
		end else if (cfg_load_q || por_event) begin
			brownout_enable <= user_config_word_zero[CFG_BRN_EN_BIT];
			brownout_level_select <= user_config_word_zero[CFG_BRN_LVL_LSB +: 2];
			brownout_reset_enable <= user_config_word_zero[CFG_BRN_RST_BIT];
		end else if (brownout_ctl_wr) begin
			brownout_enable <= brownout_ctl[BODCTL_EN_BIT];
			brownout_level_select <= brownout_ctl[BODCTL_LVL_LSB +: 2];
		end
	end

	logic brn_low_q;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			brn_low_q <= 1'b0;
			brownout_int_flag <= 1'b0;
		end else begin
			brn_low_q <= brn_low;
			// A new event wins over a clear in the same cycle
			if (brn_low && !brn_low_q) begin
				brownout_int_flag <= 1'b1;
			end else if (brownout_ctl_wr && brownout_ctl[BODCTL_IFCLR_BIT]) begin
				brownout_int_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Reset sources
	// ------------------------------------------------------------
	logic chip_req;
	logic mcu_req;
	logic core_req;
	logic brn_rst;
	logic [RS_N-1:0] src_ev;
	logic [3:0] hold_q;

	assign chip_req = ip_reset_wr && ip_reset_ctl_0[IPRST_CHIP_BIT];
	assign core_req = ip_reset_wr && ip_reset_ctl_0[IPRST_CORE_BIT];
	assign mcu_req = aircr_wr && app_interrupt_reset_ctl[AIRCR_SYSRST_BIT];
	assign brn_rst = brn_low && brownout_reset_enable;

	always_comb begin
		src_ev = '0;
		src_ev[RS_POR] = por_event;
		src_ev[RS_PIN] = pin_low;
		src_ev[RS_WDT] = wdt_timeout || window_wdt_timeout;
		src_ev[RS_LOWV] = low_voltage_reset;
		src_ev[RS_BRN] = brn_rst;
		src_ev[RS_LOCKUP] = core_lockup;
		src_ev[RS_CHIP] = chip_req;
		src_ev[RS_MCU] = mcu_req;
		src_ev[RS_CORE] = core_req;
	end

	// Flags sit outside the chip reset so software can see what caused it
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			reset_source_status <= '0;
		end else begin
			for (int i = 0; i < RS_N; i++) begin
				if (src_ev[i]) begin
					reset_source_status[i] <= 1'b1;
				end else if (status_clr_wr && status_clr_mask[i]) begin
					reset_source_status[i] <= 1'b0;
				end
			end
		end
	end

	// Software resets hold for a few cycles; level sources hold while active
	logic sys_src;
	assign sys_src = |src_ev[RS_MCU:RS_POR];

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			hold_q <= 4'h0;
			chip_rst <= 1'b0;
			core_rst <= 1'b0;
		end else begin
			if (sys_src || core_req) begin
				hold_q <= 4'(RST_HOLD_CYC);
			end else if (hold_q != 4'h0) begin
				hold_q <= hold_q - 4'h1;
			end
			if (sys_src) begin
				chip_rst <= 1'b1;
				core_rst <= 1'b1;
			end else if (core_req) begin
				core_rst <= 1'b1;
			end else if (hold_q == 4'h1) begin
				chip_rst <= 1'b0;
				core_rst <= 1'b0;
			end
		end
	end

	// Boot select: chip-level resets reload it, MCU reset keeps it
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			boot_select_bit <= 1'b0;
		end else if (cfg_load_q || (sys_src && !mcu_req)) begin
			boot_select_bit <= user_config_word_zero[BOOT_SEL_BIT];
		end else if (mcu_req) begin
			boot_select_bit <= boot_select_bit;
		end else if (boot_sel_wr) begin
			boot_select_bit <= boot_sel_wdata;
		end
	end

	// ------------------------------------------------------------
	// Power modes
	// ------------------------------------------------------------
	rpm_mode_t mode_q;
	rpm_mode_t mode_d;
	logic sda_q;
	logic scl_q;
	logic tw_wake;
	logic pd_wake;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sda_q <= 1'b1;
			scl_q <= 1'b1;
		end else begin
			sda_q <= tw_sda;
			scl_q <= tw_scl;
		end
	end

	assign tw_wake = (sda_q && !tw_sda) || (scl_q && !tw_scl);
	assign pd_wake = wake_wdt || tw_wake || wake_timer || wake_serial || wake_brownout ||
		wake_gpio;

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			RPM_NORMAL: begin
				if (wfi && sleep_deep && pd_enable) begin
					mode_d = RPM_PDOWN;
				end else if (wfi) begin
					mode_d = RPM_IDLE;
				end
			end
			RPM_IDLE: begin
				if (any_irq) begin
					mode_d = RPM_NORMAL;
				end
			end
			RPM_PDOWN: begin
				if (pd_wake) begin
					mode_d = RPM_NORMAL;
				end
			end
			default: mode_d = RPM_NORMAL;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= RPM_NORMAL;
		end else if (chip_rst || core_rst) begin
			mode_q <= RPM_NORMAL;
		end else begin
			mode_q <= mode_d;
		end
	end

	assign power_mode = mode_q;
	assign core_clk_en = (mode_q == RPM_NORMAL);
	assign hclk_en = (mode_q != RPM_PDOWN);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	rpm_addr_decode u_dec (
		.addr(bus_addr),
		.sel(bus_sel),
		.unmapped(bus_unmapped)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_flag_set;
		@(posedge clock) disable iff (sys_rst) src_ev[RS_LOCKUP] |=> reset_source_status[RS_LOCKUP];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("lockup flag not set");

	property p_sys_rst;
		@(posedge clock) disable iff (sys_rst) sys_src |=> chip_rst && core_rst;
	endproperty
	a_sys_rst: assert property (p_sys_rst) else $error("system reset not issued");

	property p_core_only;
		@(posedge clock) disable iff (sys_rst)
			(core_req && !sys_src && !chip_rst) |=> core_rst && !chip_rst;
	endproperty
	a_core_only: assert property (p_core_only) else $error("core reset wrong");

	property p_mcu_keep;
		@(posedge clock) disable iff (sys_rst)
			(mcu_req && !cfg_load_q) |=> boot_select_bit == $past(boot_select_bit);
	endproperty
	a_mcu_keep: assert property (p_mcu_keep) else $error("boot select changed");

	property p_brn_off;
		@(posedge clock) disable iff (sys_rst) !brownout_enable |=> !brn_low;
	endproperty
	a_brn_off: assert property (p_brn_off) else $error("brown-out seen while off");

	property p_brn_glitch;
		@(posedge clock) disable iff (sys_rst) $rose(brn_low) |-> $past(brn_raw, 4);
	endproperty
	a_brn_glitch: assert property (p_brn_glitch) else $error("brown-out too fast");

	property p_sticky;
		@(posedge clock) disable iff (sys_rst)
			(reset_source_status[RS_POR] && !(status_clr_wr && status_clr_mask[RS_POR]))
			|=> reset_source_status[RS_POR];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");

	property p_idle;
		@(posedge clock) disable iff (sys_rst)
			(mode_q == RPM_NORMAL && wfi && !(sleep_deep && pd_enable) && !chip_rst && !core_rst)
			|=> mode_q == RPM_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("idle not entered");

	property p_pd_hold;
		@(posedge clock) disable iff (sys_rst)
			(mode_q == RPM_PDOWN && !pd_wake && !chip_rst && !core_rst) |=> mode_q == RPM_PDOWN;
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("power-down left early");

	c_pdown: cover property (@(posedge clock) disable iff (sys_rst)
		mode_q == RPM_PDOWN ##1 mode_q == RPM_NORMAL);
	c_idle: cover property (@(posedge clock) disable iff (sys_rst) mode_q == RPM_IDLE);
	c_brn: cover property (@(posedge clock) disable iff (sys_rst) $rose(brn_low));
	c_chip: cover property (@(posedge clock) disable iff (sys_rst) chip_req);

endmodule : rpm_manager

`default_nettype wire

/* File: hdl/rpm_pkg.sv */
package rpm_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int BRN_GLITCH_HCLK = 20;
	// Low-frequency RC oscillator taken as 10 kHz, one cycle is 100000 ns
	localparam int LFRC_PERIOD_NS = 100000;
	localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
	localparam int LFRC_CYCLES = (LFRC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BRN_GLITCH_CYC = (LFRC_CYCLES > BRN_GLITCH_HCLK) ? LFRC_CYCLES :
		BRN_GLITCH_HCLK;
	// Reset outputs stay up this many edges after the last request
	localparam int RST_HOLD_CYC = 3;
	localparam int EXT_RST_IRC_CYCLES = 768;
	// Internal RC at 22.1184 MHz: 768 cycles are 34722 ns, rounded up
	localparam int EXT_RST_NS = 34723;
	localparam int EXT_RST_CYC = (EXT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Bit positions
	// ------------------------------------------------------------
	localparam int IPRST_CHIP_BIT = 0;
	localparam int IPRST_CORE_BIT = 1;
	localparam int AIRCR_SYSRST_BIT = 2;
	localparam int BOOT_SEL_BIT = 1;
	localparam int BODCTL_EN_BIT = 0;
	localparam int BODCTL_LVL_LSB = 1;
	localparam int BODCTL_IFCLR_BIT = 4;
	localparam int CFG_BRN_EN_BIT = 23;
	localparam int CFG_BRN_LVL_LSB = 21;
	localparam int CFG_BRN_RST_BIT = 20;

	// Reset source status flag positions
	localparam int RS_POR = 0;
	localparam int RS_PIN = 1;
	localparam int RS_WDT = 2;
	localparam int RS_LOWV = 3;
	localparam int RS_BRN = 4;
	localparam int RS_LOCKUP = 5;
	localparam int RS_CHIP = 6;
	localparam int RS_MCU = 7;
	localparam int RS_CORE = 8;
	localparam int RS_N = 9;

	// ------------------------------------------------------------
	// Memory map
	// ------------------------------------------------------------
	localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
	localparam logic [31:0] FLASH_LAST = 32'h0000_7fff;
	localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
	localparam logic [31:0] SRAM_LAST = 32'h2000_0fff;
	localparam logic [31:0] SYS_BASE = 32'h5000_0000;
	localparam logic [31:0] SYS_LAST = 32'h5000_01ff;
	localparam logic [31:0] CLKC_BASE = 32'h5000_0200;
	localparam logic [31:0] CLKC_LAST = 32'h5000_02ff;
	localparam logic [31:0] INTM_BASE = 32'h5000_0300;
	localparam logic [31:0] INTM_LAST = 32'h5000_03ff;
	localparam logic [31:0] GPIO_BASE = 32'h5000_4000;
	localparam logic [31:0] GPIO_LAST = 32'h5000_7fff;
	localparam logic [31:0] FLC_BASE = 32'h5000_c000;
	localparam logic [31:0] FLC_LAST = 32'h5000_ffff;
	localparam logic [31:0] WDT_BASE = 32'h4000_4000;
	localparam logic [31:0] WDT_LAST = 32'h4000_40ff;
	localparam logic [31:0] WINWD_BASE = 32'h4000_4100;
	localparam logic [31:0] WINWD_LAST = 32'h4000_47ff;
	localparam logic [31:0] TMR_BASE = 32'h4001_0000;
	localparam logic [31:0] TW0_BASE = 32'h4002_0000;
	localparam logic [31:0] SPI_BASE = 32'h4003_0000;
	localparam logic [31:0] PWM_BASE = 32'h4004_0000;
	localparam logic [31:0] SER0_BASE = 32'h4005_0000;
	localparam logic [31:0] ACMP_BASE = 32'h400d_0000;
	localparam logic [31:0] ADC_BASE = 32'h400e_0000;
	localparam logic [31:0] TW1_BASE = 32'h4012_0000;
	localparam logic [31:0] SER1_BASE = 32'h4015_0000;
	localparam logic [31:0] APB_WIN_MASK = 32'hffff_c000;
	localparam logic [31:0] SYST_BASE = 32'he000_e010;
	localparam logic [31:0] SYST_LAST = 32'he000_e0ff;
	localparam logic [31:0] NVIC_BASE = 32'he000_e100;
	localparam logic [31:0] NVIC_LAST = 32'he000_ecff;
	localparam logic [31:0] SCB_BASE = 32'he000_ed00;
	localparam logic [31:0] SCB_LAST = 32'he000_ed8f;

	// One-hot select positions
	localparam int SEL_FLASH = 0;
	localparam int SEL_SRAM = 1;
	localparam int SEL_SYS = 2;
	localparam int SEL_CLKC = 3;
	localparam int SEL_INTM = 4;
	localparam int SEL_GPIO = 5;
	localparam int SEL_FLC = 6;
	localparam int SEL_WDT = 7;
	localparam int SEL_WINWD = 8;
	localparam int SEL_TMR = 9;
	localparam int SEL_TW0 = 10;
	localparam int SEL_SPI = 11;
	localparam int SEL_PWM = 12;
	localparam int SEL_SER0 = 13;
	localparam int SEL_ACMP = 14;
	localparam int SEL_ADC = 15;
	localparam int SEL_TW1 = 16;
	localparam int SEL_SER1 = 17;
	localparam int SEL_SYST = 18;
	localparam int SEL_NVIC = 19;
	localparam int SEL_SCB = 20;
	localparam int SEL_N = 21;

	typedef enum logic [1:0] {
		RPM_NORMAL,
		RPM_IDLE,
		RPM_PDOWN
	} rpm_mode_t;

endpackage : rpm_pkg

/* File: sim/reset_power_mode_manager_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module reset_power_mode_manager_tb_top;
	import rpm_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] hw = 5'h00;
	logic ext_n = 1'b1, ip_wr = 1'b0, air_wr = 1'b0, bc_wr = 1'b0, bsel_wr = 1'b0, bsel_d = 1'b0;
	logic clr_wr = 1'b0, wfi = 1'b0, sdeep = 1'b0, pden = 1'b0, irq = 1'b0;
	logic [3:0] below = 4'h0;
	logic [31:0] cfg = 32'h00b0_0002, ipd = 32'h0, aird = 32'h0, bcd = 32'h0, addr = 32'h0;
	logic [RS_N-1:0] clr_m = '0;
	logic [6:0] wreq = 7'h00;
	logic [4:0] wf;
	logic sda, scl, chip_rst, core_rst, boot, b_en, b_rst_en, b_det, b_if, core_ce, hclk_ce, unm;
	logic [1:0] b_lvl, mode;
	logic [RS_N-1:0] st;
	logic [SEL_N-1:0] sel;
	int errors = 0;
	int n_compared = 0;
	int hw_bit[5] = '{RS_POR, RS_WDT, RS_WDT, RS_LOWV, RS_LOCKUP};
	logic [31:0] dec_a[14] = '{32'h0000_7fff, 32'h0000_8000, 32'h2000_0fff, 32'h2000_1000,
		32'h5000_0000, 32'h5000_0200, 32'h5000_0300, 32'h5000_4000, 32'h5000_c000,
		32'h4001_3fff, 32'h4002_0000, 32'h4012_3ffc, 32'he000_ed00, 32'he000_e100};
	int dec_i[14] = '{SEL_FLASH, -1, SEL_SRAM, -1, SEL_SYS, SEL_CLKC, SEL_INTM, SEL_GPIO,
		SEL_FLC, SEL_TMR, SEL_TW0, SEL_TW1, SEL_SCB, SEL_NVIC};

	always #20 clock = !clock;

	rpm_manager rpm_manager_i (.clock(clock), .sys_rst(sys_rst), .por_event(hw[0]),
		.external_reset_pin_n(ext_n), .wdt_timeout(hw[1]), .window_wdt_timeout(hw[2]),
		.low_voltage_reset(hw[3]), .core_lockup(hw[4]), .avdd_below_low(1'b0),
		.avdd_below_lvl(below), .user_config_word_zero(cfg), .ip_reset_wr(ip_wr),
		.ip_reset_ctl_0(ipd), .aircr_wr(air_wr), .app_interrupt_reset_ctl(aird),
		.brownout_ctl_wr(bc_wr), .brownout_ctl(bcd),
		.boot_sel_wr(bsel_wr), .boot_sel_wdata(bsel_d),
		.status_clr_wr(clr_wr), .status_clr_mask(clr_m), .wfi(wfi), .sleep_deep(sdeep),
		.pd_enable(pden), .any_irq(irq), .wake_wdt(wf[0]), .wake_timer(wf[1]),
		.wake_serial(wf[2]), .wake_brownout(wf[3]), .wake_gpio(wf[4]),
		.tw_sda(sda), .tw_scl(scl),
		.bus_addr(addr), .reset_source_status(st), .chip_rst(chip_rst), .core_rst(core_rst),
		.boot_select_bit(boot), .brownout_enable(b_en), .brownout_level_select(b_lvl),
		.brownout_reset_enable(b_rst_en), .brownout_detected(b_det), .brownout_int_flag(b_if),
		.power_mode(mode), .core_clk_en(core_ce), .hclk_en(hclk_ce), .bus_sel(sel),
		.bus_unmapped(unm));

	rpm_periph_model rpm_periph_model_i (.clock(clock), .sys_rst(sys_rst), .power_mode(mode),
		.wake_req(wreq), .wake_flags(wf), .tw_sda(sda), .tw_scl(scl));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	// One-cycle strobe, then one more cycle so the answer has landed
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask : pulse

	task automatic settle(input int lim);
		int k;
		k = 0;
		while ((chip_rst !== 1'b0 || core_rst !== 1'b0) && k < lim) begin
			cyc(1);
			k++;
		end
		check("reset release", {chip_rst, core_rst}, 0);
	endtask : settle

	task automatic print_verdict();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#(40 * 40000);
		errors++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		cyc(20);
		sys_rst = 1'b0;
		cyc(3);
		check("cfg defaults", {b_en, b_lvl, b_rst_en, boot}, 5'b10111);
		for (int i = 0; i < 14; i++) begin
			addr = dec_a[i];
			cyc(1);
			check("decode sel", sel, dec_i[i] < 0 ? 0 : 1 << dec_i[i]);
			check("decode unmapped", unm, dec_i[i] < 0);
		end
		for (int i = 0; i < 5; i++) begin
			hw = 5'(1 << i);
			cyc(1);
			hw = 5'h00;
			cyc(1);
			check("hw chip_rst", chip_rst, 1);
			check("hw status", st[hw_bit[i]], 1);
			settle(20);
		end
		bsel_d = 1'b0;
		pulse(bsel_wr);
		ipd = 32'h1;
		pulse(ip_wr);
		check("chip reset", {chip_rst, core_rst, st[RS_CHIP]}, 3'b111);
		check("boot reload", boot, 1);
		settle(20);
		ipd = 32'h2;
		pulse(ip_wr);
		check("core reset", {chip_rst, core_rst, st[RS_CORE]}, 3'b011);
		settle(20);
		pulse(bsel_wr);
		aird = 32'h4;
		pulse(air_wr);
		check("mcu reset", {st[RS_MCU], boot}, 2'b10);
		settle(20);
		ext_n = 1'b0;
		cyc(EXT_RST_CYC - 20);
		check("pin early", chip_rst, 0);
		cyc(40);
		check("pin reset", {chip_rst, st[RS_PIN]}, 2'b11);
		ext_n = 1'b1;
		settle(EXT_RST_CYC + 20);
		check("status kept", st, 9'h1ef);
		clr_m = '1;
		pulse(clr_wr);
		check("status cleared", st, 0);
		bcd = 32'h3;
		pulse(bc_wr);
		below = 4'b0100;
		cyc(BRN_GLITCH_CYC + 10);
		check("brownout other level", b_det, 0);
		below = 4'b0010;
		cyc(BRN_GLITCH_CYC - 10);
		check("brownout early", b_det, 0);
		cyc(20);
		check("brownout reset", {b_det, chip_rst, st[RS_BRN]}, 3'b111);
		check("brownout int flag", b_if, 1);
		below = 4'b0000;
		cyc(BRN_GLITCH_CYC - 10);
		check("brownout hold", b_det, 1);
		cyc(20);
		check("brownout release", b_det, 0);
		settle(20);
		// Enable off, level kept, write one to clear the interrupt flag
		bcd = 32'h12;
		pulse(bc_wr);
		check("brownout flag clear", {b_en, b_if}, 2'b00);
		below = 4'b0010;
		cyc(BRN_GLITCH_CYC + 10);
		check("brownout disabled", b_det, 0);
		below = 4'b0000;
		pulse(wfi);
		check("idle", {mode, core_ce, hclk_ce}, {RPM_IDLE, 2'b01});
		irq = 1'b1;
		cyc(2);
		check("idle wake", mode, RPM_NORMAL);
		irq = 1'b0;
		sdeep = 1'b1;
		pden = 1'b1;
		for (int i = 0; i < 7; i++) begin
			pulse(wfi);
			check("pdown", {mode, hclk_ce}, {RPM_PDOWN, 1'b0});
			irq = 1'b1;
			cyc(3);
			check("pdown irq", mode, RPM_PDOWN);
			irq = 1'b0;
			wreq[i] = 1'b1;
			cyc(1);
			wreq = 7'h00;
			cyc(4);
			check("pdown wake", mode, RPM_NORMAL);
		end
		print_verdict();
	end
endmodule : reset_power_mode_manager_tb_top

`default_nettype wire

/* File: sim/rpm_periph_model.sv */
`timescale 1ns/10ps
`default_nettype none

module rpm_periph_model
	import rpm_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [1:0] power_mode,
	input wire logic [6:0] wake_req,
	output logic [4:0] wake_flags,
	output logic tw_sda,
	output logic tw_scl
);
	// ------------------------------------------------------------
	// Wake flags: wdt, timer, serial, brown-out, pins
	// ------------------------------------------------------------
	// Software clears each flag once back in normal mode, so a later power-down is not cut short
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wake_flags <= 5'h00;
		end else if (power_mode == RPM_NORMAL) begin
			wake_flags <= 5'h00;
		end else begin
			wake_flags <= wake_flags | wake_req[4:0];
		end
	end

	// ------------------------------------------------------------
	// Two-wire lines
	// ------------------------------------------------------------
	// Lines rest high on their pull-ups; request bit 5 pulls data, bit 6 clock, low one cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			tw_sda <= 1'b1;
			tw_scl <= 1'b1;
		end else begin
			tw_sda <= !wake_req[5];
			tw_scl <= !wake_req[6];
		end
	end
endmodule : rpm_periph_model

`default_nettype wire
